// file: dec_skip_defs.svh
/*
 * Constants for the decrement-and-skip execution block: opcode fields,
 * addressing limits, quarter-phase counts and reset values.
 * Assumes it is included by bare name from the execution module and the bench.
 */
`ifndef DEC_SKIP_DEFS_SVH
`define DEC_SKIP_DEFS_SVH

// ====================================================================
// opcode fields (bits 15:10 of the program word)
`define OPC_DEC_SKIP_IF_ZERO    6'h0b
`define OPC_DEC_SKIP_IF_NONZERO 6'h13
`define OPC_HI                  15
`define OPC_LO                  10
`define DEST_BIT                9
`define ACCESS_BIT              8

// ====================================================================
// addressing
`define INDEXED_LIMIT           8'h5f
`define ACCESS_SPLIT            8'h60
`define ACCESS_HIGH_BANK        4'hf
`define ACCESS_LOW_BANK         4'h0

// ====================================================================
// timing and reset values
`define QUARTERS_PER_CYCLE      3'h4
`define PC_STEP                 21'h000002
`define RESET_BYTE              8'h00

`endif

// file: dec_skip_exec.sv
/*
 * Execution of the two decrement-and-skip instructions across four
 * quarter-phases, with operand addressing and skip no-operation cycles.
 * Assumes the core offers instruction word, prefetch word-count flag, a
 * one-cycle-latency-free file read port, bank select and extended mode.
 */
`include "dec_skip_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - an instruction takes one cycle without skip, two with skip, three if the skipped one has two words.
// - every extra skip cycle is four quarters of no operation, two such cycles for a two-word victim.
// - the not-zero variant decrements, writes the destination and skips only on a nonzero result.
// - a skip discards the prefetched instruction and runs a no-operation in its place.
// - the not-zero variant is decoded from opcode 0100 11 then d, a and an 8-bit file address.
// - with access bit one the operand lies in the bank named by the bank select register.
// - with access bit zero and extended mode off the operand lies in the access bank.
// - with extended mode on, access bit zero and address up to 5Fh the operand is indexed literal offset.
// - the zero variant with a nonzero result continues at the next word, two bytes on, with no added cycles.
// - destination bit zero writes the working register, one writes the file register back.
module dec_skip_exec
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// instruction issue
	input  wire logic        issue_in,
	input  wire logic [15:0] instr_in,
	input  wire logic [20:0] pc_in,
	input  wire logic        next_two_word_in,
	// addressing context
	input  wire logic [3:0]  bank_select_register_in,
	input  wire logic        ext_mode_in,
	input  wire logic [11:0] index_base_in,
	// file read data
	input  wire logic [7:0]  file_rdata_in,
	// file access
	output logic             file_rd_out,
	output logic [11:0]      file_addr_out,
	output logic             file_wr_out,
	output logic [7:0]       file_wdata_out,
	// working register write
	output logic             wreg_wr_out,
	output logic [7:0]       wreg_wdata_out,
	// pipeline control
	output logic             busy_out,
	output logic             nop_out,
	output logic             flush_out,
	output logic             done_out,
	output logic [20:0]      next_pc_out
);

	dec_skip_pkg::quarter_t      quarter;
	dec_skip_pkg::exec_state_t   st_r, st_nxt;
	logic        run, is_z, is_nz, hit, skip;
	logic        dest_r, dest_nxt, nz_r, nz_nxt, two_r, two_nxt;
	logic [11:0] addr_r, addr_nxt;
	logic [7:0]  res_r, res_nxt, wdata_r, wdata_nxt;
	logic [20:0] pc_r, pc_nxt, npc_r, npc_nxt;
	logic        rd_nxt, fwr_nxt, wwr_nxt, busy_nxt, nop_nxt, flush_nxt, done_nxt;
	logic        rd_r, fwr_r, wwr_r, busy_r, nop_r, flush_r, done_r;

	assign run   = (st_r != dec_skip_pkg::ST_IDLE);
	assign is_z  = (instr_in[`OPC_HI:`OPC_LO] == `OPC_DEC_SKIP_IF_ZERO);
	assign is_nz = (instr_in[`OPC_HI:`OPC_LO] == `OPC_DEC_SKIP_IF_NONZERO);
	assign hit   = issue_in && (st_r == dec_skip_pkg::ST_IDLE) && (is_z || is_nz);
	// skip sense: zero variant on zero, not-zero variant on nonzero
	assign skip  = nz_r ? (res_r != `RESET_BYTE) : (res_r == `RESET_BYTE);
	quarter_gen u_quarter
	(
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.run_in      (run),
		.quarter_out (quarter)
	);

	// ====================================================================
	// decode and operand addressing
	always_comb
	begin
		dest_nxt = dest_r;
		nz_nxt   = nz_r;
		two_nxt  = two_r;
		addr_nxt = addr_r;
		pc_nxt   = pc_r;
		if (hit)
		begin
			dest_nxt = instr_in[`DEST_BIT];
			nz_nxt   = is_nz;
			two_nxt  = next_two_word_in;
			pc_nxt   = pc_in;
			if (instr_in[`ACCESS_BIT])
				addr_nxt = {bank_select_register_in, instr_in[7:0]};
			else if (ext_mode_in && instr_in[7:0] <= `INDEXED_LIMIT)
				addr_nxt = index_base_in + {4'h0, instr_in[7:0]};
			else if (instr_in[7:0] < `ACCESS_SPLIT)
				addr_nxt = {`ACCESS_LOW_BANK, instr_in[7:0]};
			else
				addr_nxt = {`ACCESS_HIGH_BANK, instr_in[7:0]};
		end
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dest_r <= 1'b1;
			nz_r   <= 1'b0;
			two_r  <= 1'b0;
			addr_r <= 12'h000;
			pc_r   <= 21'h000000;
		end
		else
		begin
			dest_r <= dest_nxt;
			nz_r   <= nz_nxt;
			two_r  <= two_nxt;
			addr_r <= addr_nxt;
			pc_r   <= pc_nxt;
		end
	end

	// ====================================================================
	// sequencing over quarters and skip cycles
	always_comb
	begin
		st_nxt    = st_r;
		res_nxt   = res_r;
		rd_nxt    = 1'b0;
		fwr_nxt   = 1'b0;
		wwr_nxt   = 1'b0;
		wdata_nxt = wdata_r;
		busy_nxt  = run || hit;
		nop_nxt   = 1'b0;
		flush_nxt = 1'b0;
		done_nxt  = 1'b0;
		npc_nxt   = npc_r;
		case (st_r)
			dec_skip_pkg::ST_IDLE:
			begin
				if (hit)
					st_nxt = dec_skip_pkg::ST_EXEC;
			end
			dec_skip_pkg::ST_EXEC:
			begin
				case (quarter)
					dec_skip_pkg::Q1: rd_nxt = 1'b1;
					dec_skip_pkg::Q2: res_nxt = file_rdata_in - 8'h01;
					dec_skip_pkg::Q3:
					begin
						wdata_nxt = res_r;
						fwr_nxt   = dest_r;
						wwr_nxt   = !dest_r;
					end
					dec_skip_pkg::Q4:
					begin
						if (skip)
						begin
							flush_nxt = 1'b1;
							st_nxt    = dec_skip_pkg::ST_NOP1;
						end
						else
						begin
							npc_nxt  = pc_r + `PC_STEP;
							done_nxt = 1'b1;
							busy_nxt = 1'b0;
							st_nxt   = dec_skip_pkg::ST_IDLE;
						end
					end
					default: st_nxt = dec_skip_pkg::ST_IDLE;
				endcase
			end
			dec_skip_pkg::ST_NOP1, dec_skip_pkg::ST_NOP2:
			begin
				nop_nxt = 1'b1;
				if (quarter == dec_skip_pkg::Q4)
				begin
					nop_nxt = 1'b0;
					if (st_r == dec_skip_pkg::ST_NOP1 && two_r)
						st_nxt = dec_skip_pkg::ST_NOP2;
					else
					begin
						// skipped word count decides landing address
						npc_nxt  = pc_r + (two_r ? 21'h000006 : 21'h000004);
						done_nxt = 1'b1;
						busy_nxt = 1'b0;
						st_nxt   = dec_skip_pkg::ST_IDLE;
					end
				end
			end
			default: st_nxt = dec_skip_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_r    <= dec_skip_pkg::ST_IDLE;
			res_r   <= `RESET_BYTE;
			rd_r    <= 1'b0;
			fwr_r   <= 1'b0;
			wwr_r   <= 1'b0;
			wdata_r <= `RESET_BYTE;
			busy_r  <= 1'b0;
			nop_r   <= 1'b0;
			flush_r <= 1'b0;
			done_r  <= 1'b0;
			npc_r   <= 21'h000000;
		end
		else
		begin
			st_r    <= st_nxt;
			res_r   <= res_nxt;
			rd_r    <= rd_nxt;
			fwr_r   <= fwr_nxt;
			wwr_r   <= wwr_nxt;
			wdata_r <= wdata_nxt;
			busy_r  <= busy_nxt;
			nop_r   <= nop_nxt;
			flush_r <= flush_nxt;
			done_r  <= done_nxt;
			npc_r   <= npc_nxt;
		end
	end
	assign file_rd_out    = rd_r;
	assign file_addr_out  = addr_r;
	assign file_wr_out    = fwr_r;
	assign file_wdata_out = wdata_r;
	assign wreg_wr_out    = wwr_r;
	assign wreg_wdata_out = wdata_r;
	assign busy_out       = busy_r;
	assign nop_out        = nop_r;
	assign flush_out      = flush_r;
	assign done_out       = done_r;
	assign next_pc_out    = npc_r;

	// ====================================================================
	// checks
	property p_excl_dest;
		@(posedge clk_in) disable iff (rst_in) !(fwr_r && wwr_r);
	endproperty
	a_excl_dest: assert property (p_excl_dest) else $error("both destinations written");
	property p_dest_choice;
		@(posedge clk_in) disable iff (rst_in) (fwr_r || wwr_r) |-> (fwr_r == dest_r);
	endproperty
	a_dest_choice: assert property (p_dest_choice) else $error("wrong destination");
	property p_noskip_pc;
		@(posedge clk_in) disable iff (rst_in)
		(st_r == dec_skip_pkg::ST_EXEC && quarter == dec_skip_pkg::Q4 && !skip)
			|=> done_r && npc_r == $past(pc_r) + 21'h000002;
	endproperty
	a_noskip_pc: assert property (p_noskip_pc) else $error("no-skip landing wrong");
	// flush lands one clock before the three idle quarters, done closes the cycle
	sequence s_exec;
		(st_r == dec_skip_pkg::ST_EXEC && quarter == dec_skip_pkg::Q4 && skip && !two_r);
	endsequence
	property p_one_nop;
		@(posedge clk_in) disable iff (rst_in) s_exec |=> flush_r ##1 nop_r [*3] ##1 done_r;
	endproperty
	a_one_nop: assert property (p_one_nop) else $error("single skip cycle wrong");
	property p_two_nop;
		@(posedge clk_in) disable iff (rst_in)
		(st_r == dec_skip_pkg::ST_EXEC && quarter == dec_skip_pkg::Q4 && skip && two_r)
			|=> ##8 done_r && npc_r == $past(pc_r, 9) + 21'h000006;
	endproperty
	a_two_nop: assert property (p_two_nop) else $error("two-word skip wrong");
	property p_flush_skip;
		@(posedge clk_in) disable iff (rst_in) flush_r |-> $past(skip) && !done_r;
	endproperty
	a_flush_skip: assert property (p_flush_skip) else $error("flush without skip");
	property p_access_bank;
		@(posedge clk_in) disable iff (rst_in)
		hit && instr_in[`ACCESS_BIT] |=> addr_r[11:8] == $past(bank_select_register_in);
	endproperty
	a_access_bank: assert property (p_access_bank) else $error("bank select ignored");
	property p_access_low;
		@(posedge clk_in) disable iff (rst_in)
		hit && !instr_in[`ACCESS_BIT] && !ext_mode_in && instr_in[7:0] < 8'h60
			|=> addr_r[11:8] == 4'h0;
	endproperty
	a_access_low: assert property (p_access_low) else $error("access bank wrong");
	property p_read_then_write;
		@(posedge clk_in) disable iff (rst_in)
		rd_r |-> ##2 (fwr_r || wwr_r) && wdata_r == res_r;
	endproperty
	a_read_then_write: assert property (p_read_then_write) else $error("quarter order broken");
	property p_nz_skip;
		@(posedge clk_in) disable iff (rst_in)
		(st_r == dec_skip_pkg::ST_EXEC && quarter == dec_skip_pkg::Q4 && nz_r)
			|=> flush_r == ($past(res_r) != 8'h00);
	endproperty
	a_nz_skip: assert property (p_nz_skip) else $error("not-zero skip sense wrong");
	property p_decode_nz;
		@(posedge clk_in) disable iff (rst_in) hit && instr_in[15:10] == 6'h13 |=> nz_r;
	endproperty
	a_decode_nz: assert property (p_decode_nz) else $error("decode wrong");

endmodule

`default_nettype wire

// file: dec_skip_pkg.sv
/*
 * Types for the decrement-and-skip execution block.
 * Assumes dec_skip_defs.svh sits in the same folder.
 */
package dec_skip_pkg;

	typedef enum logic [3:0]
	{
		Q1 = 4'h1,
		Q2 = 4'h2,
		Q3 = 4'h4,
		Q4 = 4'h8
	} quarter_t;

	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'h1,
		ST_EXEC  = 4'h2,
		ST_NOP1  = 4'h4,
		ST_NOP2  = 4'h8
	} exec_state_t;

endpackage

// file: decrement_skip_instructions_bench.sv
/*
 * Self-checking bench for dec_skip_exec: reset values, then a table of
 * ordinary decrements, foreign opcodes, issue while busy and reset mid-run.
 * Assumes dec_skip_defs.svh and dec_skip_pkg.sv are compiled first.
 */
`include "dec_skip_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module decrement_skip_instructions_bench;

	typedef struct packed
	{
		logic [15:0] ins;
		logic [7:0]  data;
		logic [3:0]  bank;
		logic        ext;
		logic        two;
		logic        skip;
	} row_t;

	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        issue_in = 1'b0;
	logic [15:0] instr_in = 16'h0000;
	logic [20:0] pc_in = 21'h000000;
	logic        next_two_word_in = 1'b0;
	logic [3:0]  bank_select_register_in = 4'h0;
	logic        ext_mode_in = 1'b0;
	logic [11:0] index_base_in = 12'h123;
	logic [7:0]  file_rdata_in = 8'h00;
	logic        file_rd_out, file_wr_out, wreg_wr_out;
	logic [11:0] file_addr_out;
	logic [7:0]  file_wdata_out, wreg_wdata_out;
	logic        busy_out, nop_out, flush_out, done_out;
	logic [20:0] next_pc_out;
	int          err_count = 0;
	int          checks = 0;

	localparam logic [5:0] OZ = `OPC_DEC_SKIP_IF_ZERO;
	localparam logic [5:0] ON = `OPC_DEC_SKIP_IF_NONZERO;

	// ins, data, bank, ext, two-word victim, expected skip
	row_t rows [8] = '{
		'{{OZ, 2'b11, 8'h34}, 8'h01, 4'h3, 1'b0, 1'b0, 1'b1},
		'{{OZ, 2'b00, 8'h20}, 8'h05, 4'h7, 1'b0, 1'b0, 1'b0},
		'{{OZ, 2'b10, 8'h80}, 8'h01, 4'h2, 1'b0, 1'b1, 1'b1},
		'{{ON, 2'b10, 8'h5f}, 8'h01, 4'h4, 1'b1, 1'b0, 1'b0},
		'{{ON, 2'b00, 8'h60}, 8'h00, 4'h5, 1'b1, 1'b0, 1'b1},
		'{{ON, 2'b01, 8'hff}, 8'h09, 4'hf, 1'b1, 1'b1, 1'b1},
		'{{ON, 2'b10, 8'h00}, 8'h02, 4'h6, 1'b0, 1'b0, 1'b1},
		'{{OZ, 2'b00, 8'h10}, 8'h00, 4'h1, 1'b1, 1'b1, 1'b0}
	};

	always #5 clk_in = ~clk_in;

	dec_skip_exec uut
	(
		.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .instr_in(instr_in),
		.pc_in(pc_in), .next_two_word_in(next_two_word_in),
		.bank_select_register_in(bank_select_register_in), .ext_mode_in(ext_mode_in),
		.index_base_in(index_base_in), .file_rdata_in(file_rdata_in),
		.file_rd_out(file_rd_out), .file_addr_out(file_addr_out), .file_wr_out(file_wr_out),
		.file_wdata_out(file_wdata_out), .wreg_wr_out(wreg_wr_out),
		.wreg_wdata_out(wreg_wdata_out), .busy_out(busy_out), .nop_out(nop_out),
		.flush_out(flush_out), .done_out(done_out), .next_pc_out(next_pc_out)
	);

	// ====================================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		if (err_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [11:0] exp_addr(input row_t r);
		logic [7:0] f;
		f = r.ins[7:0];
		if (r.ins[`ACCESS_BIT])
			return {r.bank, f};
		if (r.ext && f <= `INDEXED_LIMIT)
			return index_base_in + {4'h0, f};
		return (f < `ACCESS_SPLIT) ? {`ACCESS_LOW_BANK, f} : {`ACCESS_HIGH_BANK, f};
	endfunction

	task automatic check_idle;
		check(32'({busy_out, nop_out, flush_out, done_out, file_rd_out, file_wr_out, wreg_wr_out}), 0);
		check(32'({file_wdata_out, wreg_wdata_out, file_addr_out}), 0);
		check(32'(next_pc_out), 0);
	endtask

	// mode 0 plain, 1 second issue while busy, 2 reset mid-run
	task automatic run_op(input row_t r, input logic [20:0] pc, input int mode);
		int         k, done_k, rd_k, wr_k, nops, fl, wf, ww, bsy;
		logic [7:0] res;
		logic       d;
		res = r.data - 8'h01;
		d = r.ins[`DEST_BIT];
		done_k = 0;
		rd_k = 0;
		wr_k = 0;
		nops = 0;
		fl = 0;
		wf = 0;
		ww = 0;
		bsy = 0;
		@(posedge clk_in);
		instr_in <= r.ins;
		pc_in <= pc;
		file_rdata_in <= r.data;
		bank_select_register_in <= r.bank;
		ext_mode_in <= r.ext;
		next_two_word_in <= r.two;
		issue_in <= 1'b1;
		@(posedge clk_in);
		issue_in <= 1'b0;
		for (k = 1; k <= 20 && done_k == 0; k++)
		begin
			@(posedge clk_in);
			if (mode == 1)
			begin
				issue_in <= (k == 2);
				pc_in <= pc + 21'h000100;
			end
			if (mode == 2 && k == 5)
				rst_in <= 1'b1;
			#1;
			if (mode == 2 && k == 5)
			begin
				check_idle();
				return;
			end
			if (file_rd_out === 1'b1) rd_k = k;
			if (file_wr_out === 1'b1 || wreg_wr_out === 1'b1) wr_k = k;
			nops += (nop_out === 1'b1);
			bsy += (busy_out === 1'b1);
			fl += (flush_out === 1'b1);
			wf += (file_wr_out === 1'b1);
			ww += (wreg_wr_out === 1'b1);
			if (done_out === 1'b1) done_k = k;
		end
		if (done_k == 0)
		begin
			check(0, 1);
			test_done();
		end
		// one instruction cycle is four clocks; each skip cycle adds four more
		check(done_k, 4 + (r.skip ? (r.two ? 8 : 4) : 0));
		check(bsy, 3 + (r.skip ? (r.two ? 8 : 4) : 0));
		check(nops, r.skip ? (r.two ? 6 : 3) : 0);
		check(fl, 32'(r.skip));
		check(32'(next_pc_out), 32'(pc) + (r.skip ? (r.two ? 6 : 4) : 2));
		check(rd_k, 1);
		check(wr_k, 3);
		check(32'(file_addr_out), 32'(exp_addr(r)));
		check(wf, 32'(d));
		check(ww, 32'(!d));
		check(32'({file_wdata_out, wreg_wdata_out}), 32'({res, res}));
	endtask

	// foreign opcode must leave the block idle
	task automatic probe_ignore(input logic [5:0] opc);
		@(posedge clk_in);
		instr_in <= {opc, 2'b11, 8'h42};
		issue_in <= 1'b1;
		@(posedge clk_in);
		issue_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		#1;
		check(32'({busy_out, file_rd_out}), 0);
	endtask

	// ====================================================================
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk_in);
		#1;
		check_idle();
		@(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 8; i++)
			run_op(rows[i], 21'h000100 + 21'(i * 16), 0);
		foreach (rows[i])
			probe_ignore((i[0] ? 6'h13 : 6'h0b) ^ 6'(i + 1));
		run_op(rows[0], 21'h000400, 1);
		run_op(rows[5], 21'h000500, 2);
		@(posedge clk_in);
		rst_in <= 1'b0;
		run_op(rows[2], 21'h000600, 0);
		test_done();
	end

endmodule

`default_nettype wire

// file: quarter_gen.sv
/*
 * Quarter-phase sequencer: steps Q1..Q4 one per clock while running.
 * Assumes the caller holds run_in high for whole instruction cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module quarter_gen
(
	// clock and reset
	input  wire logic                clk_in,
	input  wire logic                rst_in,
	// control
	input  wire logic                run_in,
	// phase
	output var  dec_skip_pkg::quarter_t quarter_out
);

	dec_skip_pkg::quarter_t q_r;
	dec_skip_pkg::quarter_t q_nxt;

	always_comb
	begin
		q_nxt = q_r;
		if (run_in)
		begin
			case (q_r)
				dec_skip_pkg::Q1: q_nxt = dec_skip_pkg::Q2;
				dec_skip_pkg::Q2: q_nxt = dec_skip_pkg::Q3;
				dec_skip_pkg::Q3: q_nxt = dec_skip_pkg::Q4;
				dec_skip_pkg::Q4: q_nxt = dec_skip_pkg::Q1;
				default:          q_nxt = dec_skip_pkg::Q1;
			endcase
		end
		else
			q_nxt = dec_skip_pkg::Q1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			q_r <= dec_skip_pkg::Q1;
		else
			q_r <= q_nxt;
	end

	assign quarter_out = q_r;

endmodule

`default_nettype wire
